// File: smrm_pkg.sv
package smrm_pkg;

    // ==========================================================
    // Opcodes and extended opcodes
    // ==========================================================
    localparam logic [5:0] SMRM_PRI_MAIN = 6'h1F;
    localparam logic [5:0] SMRM_PRI_HALF = 6'h04;
    localparam logic [9:0] SMRM_XO_MFTB = 10'h173;
    localparam logic [9:0] SMRM_XO_MTCRF = 10'h090;
    localparam logic [9:0] SMRM_XO_MTDCR = 10'h1C3;
    localparam logic [9:0] SMRM_XO_MTMSR = 10'h092;
    localparam logic [9:0] SMRM_XO_MTSPR = 10'h1D3;
    localparam logic [9:0] SMRM_XO_MULCHWU = 10'h088;
    localparam logic [9:0] SMRM_XO_MULHHWU = 10'h008;
    localparam logic [8:0] SMRM_XO_MULHW = 9'h04B;
    localparam logic [8:0] SMRM_XO_MULHWU = 9'h00B;

    // ==========================================================
    // Register numbers, encoded fields and values
    // ==========================================================
    localparam logic [9:0] SMRM_TBN_LOWER = 10'h10C;
    localparam logic [9:0] SMRM_TBN_UPPER = 10'h10D;
    localparam logic [9:0] SMRM_TBF_LOWER = 10'h188;
    localparam logic [9:0] SMRM_TBF_UPPER = 10'h1A8;
    localparam logic [9:0] SMRM_DCRN_LIMIT = 10'h100;
    localparam logic [7:0] SMRM_MASK_ALL = 8'hFF;
    localparam logic [31:0] SMRM_UNDEF_VALUE = 32'h0000_0000;
    localparam logic [31:0] SMRM_CR_RESET = 32'h0000_0000;

    // ==========================================================
    // Instruction field positions (bit 0 of the word is the LSB)
    // ==========================================================
    localparam int SMRM_RC_BIT = 0;
    localparam int SMRM_SPR_PRIV_BIT = 20;

    typedef enum logic [1:0] {
        SMRM_MUL_CROSS = 2'h0,
        SMRM_MUL_HIGH = 2'h1,
        SMRM_MUL_WORD = 2'h3
    } smrm_mul_e;

    typedef enum logic [3:0] {
        SMRM_OP_NONE = 4'h0,
        SMRM_OP_MFTB = 4'h1,
        SMRM_OP_MTCRF = 4'h3,
        SMRM_OP_MTDCR = 4'h2,
        SMRM_OP_MTMSR = 4'h6,
        SMRM_OP_MTSPR = 4'h7,
        SMRM_OP_MULCH = 4'h5,
        SMRM_OP_MULHH = 4'h4,
        SMRM_OP_MULHW = 4'hC
    } smrm_op_e;

    typedef struct packed {
        logic done;
        logic wb_en;
        logic [4:0] wb_idx;
        logic [31:0] wb_data;
        logic [31:0] cr;
        logic dcr_we;
        logic spr_we;
        logic msr_we;
        logic [9:0] move_num;
        logic [31:0] move_data;
        logic exec_sync;
        logic priv_fault;
        logic invalid_form;
    } smrm_state_s;

endpackage : smrm_pkg

// File: smrm_mul_if.sv
`timescale 1ns/1ps
`default_nettype none

interface smrm_mul_if;
    import smrm_pkg::*;
    smrm_mul_e sel;
    logic sgn;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] prod;

    modport unit (input sel, input sgn, input a, input b, output prod);
    modport user (output sel, output sgn, output a, output b, input prod);
endinterface : smrm_mul_if

`default_nettype wire

// File: smrm_mul.sv
`timescale 1ns/1ps
`default_nettype none

module smrm_mul
    import smrm_pkg::*;
(
    smrm_mul_if.unit m
);

    // ==========================================================
    // Arithmetic
    // ==========================================================
    // Extension before the multiply makes one truncated product serve
    // both signed and unsigned forms; no saturation is ever applied.
    function automatic logic [31:0] smrm_hmul(input logic [15:0] x, input logic [15:0] y, input logic sgn);
        logic [31:0] xe;
        logic [31:0] ye;
        xe = sgn ? {{16{x[15]}}, x} : {16'h0000, x};
        ye = sgn ? {{16{y[15]}}, y} : {16'h0000, y};
        return xe * ye;
    endfunction : smrm_hmul

    logic [63:0] wa;
    logic [63:0] wb;
    logic [63:0] wp;

    always_comb begin
        wa = m.sgn ? {{32{m.a[31]}}, m.a} : {32'h0000_0000, m.a};
        wb = m.sgn ? {{32{m.b[31]}}, m.b} : {32'h0000_0000, m.b};
        wp = wa * wb; // RULE14 RULE16 RULE17
        case (m.sel)
            SMRM_MUL_CROSS: m.prod = smrm_hmul(m.a[15:0], m.b[31:16], m.sgn); // RULE11 RULE13
            SMRM_MUL_HIGH: m.prod = smrm_hmul(m.a[31:16], m.b[31:16], m.sgn); // RULE12 RULE13
            SMRM_MUL_WORD: m.prod = wp[63:32]; // RULE14 RULE16
            default: m.prod = 32'h0000_0000;
        endcase
    end

endmodule : smrm_mul

`default_nettype wire

// File: smrm_exec.sv
// Function
// RULE1: Move-from-time-base (31/371) swaps the halves of its 10-bit field and loads that time base word into the target.
// RULE2: Number 268 (field 0x188) selects the lower word and 269 (field 0x1A8) the upper word, both read-only.
// RULE3: Any other time base number gives an undefined result and marks the instruction form invalid.
// RULE4: Condition-field write (31/144) copies source nibble i into the condition register only where mask bit i is set.
// RULE5: The full condition-register write is the field write with all eight mask bits set.
// RULE6: A register move with bit 31 set may leave the first condition field undefined.
// RULE7: Device-control write (31/451) swaps field halves for the number and writes the source there; bad numbers are invalid.
// RULE8: Device-control write from user mode is a privilege violation.
// RULE9: Machine-state write (31/146) copies the source, is privileged and is execution synchronizing.
// RULE10: Special-purpose write (31/467) swaps field halves and is privileged only when instruction bit 11 is one.
// RULE11: Cross-halfword multiplies take low half of the first by high half of the second; unsigned form is 4/136.
// RULE12: High-halfword multiplies take both upper halves; unsigned form is 4/8.
// RULE13: Signed halfword variants treat halves as two's complement, unsigned ones as magnitudes.
// RULE14: High-word multiply (31/75) keeps the upper 32 bits of the signed 64-bit product.
// RULE15: With the record bit set, every multiply here updates lt, gt, eq and so of the first condition field.
// RULE16: Unsigned high-word multiply keeps the upper 32 bits of the unsigned 64-bit product.
// RULE17: These multiplies leave the fixed-point exception register alone and never saturate.
`timescale 1ns/1ps
`default_nettype none

module smrm_exec
    import smrm_pkg::*;
#(
    parameter logic [9:0] XO_MULCHW_SIGNED = 10'h0A8,
    parameter logic [9:0] XO_MULHHW_SIGNED = 10'h028
)(
    input wire logic clk,
    input wire logic resetn,
    input wire logic issue_valid,
    input wire logic [31:0] instr,
    input wire logic [31:0] ra_val,
    input wire logic [31:0] rb_val,
    input wire logic [31:0] rs_val,
    input wire logic user_mode,
    input wire logic xer_so,
    input wire logic [31:0] tb_lower,
    input wire logic [31:0] tb_upper,
    output logic done_q,
    output logic wb_en_q,
    output logic [4:0] wb_idx_q,
    output logic [31:0] wb_data_q,
    output logic [31:0] cr_q,
    output logic dcr_we_q,
    output logic spr_we_q,
    output logic msr_we_q,
    output logic [9:0] move_num_q,
    output logic [31:0] move_data_q,
    output logic exec_sync_q,
    output logic priv_fault_q,
    output logic invalid_form_q
);

    // ==========================================================
    // Decode helpers
    // ==========================================================
    function automatic logic [9:0] smrm_swap_half(input logic [9:0] f);
        return {f[4:0], f[9:5]};
    endfunction : smrm_swap_half

    function automatic logic [31:0] smrm_cr_merge(input logic [31:0] cr, input logic [31:0] src,
                                                  input logic [7:0] mask);
        logic [31:0] r;
        r = cr;
        for (int j = 0; j < 8; j++) begin
            if (mask[j]) begin
                r[4*j +: 4] = src[4*j +: 4];
            end
        end
        return r;
    endfunction : smrm_cr_merge

    function automatic logic [3:0] smrm_cr0(input logic [31:0] res, input logic so);
        return {res[31], !res[31] && (res != 32'h0000_0000), res == 32'h0000_0000, so};
    endfunction : smrm_cr0

    function automatic smrm_op_e smrm_classify(input logic [31:0] w);
        smrm_op_e op;
        op = SMRM_OP_NONE;
        if (w[31:26] == SMRM_PRI_MAIN) begin
            if (w[10:1] == SMRM_XO_MFTB) op = SMRM_OP_MFTB;
            else if (w[10:1] == SMRM_XO_MTCRF) op = SMRM_OP_MTCRF;
            else if (w[10:1] == SMRM_XO_MTDCR) op = SMRM_OP_MTDCR;
            else if (w[10:1] == SMRM_XO_MTMSR) op = SMRM_OP_MTMSR;
            else if (w[10:1] == SMRM_XO_MTSPR) op = SMRM_OP_MTSPR;
            else if (w[9:1] == SMRM_XO_MULHW || w[9:1] == SMRM_XO_MULHWU) op = SMRM_OP_MULHW;
        end else if (w[31:26] == SMRM_PRI_HALF) begin
            if (w[10:1] == SMRM_XO_MULCHWU || w[10:1] == XO_MULCHW_SIGNED) op = SMRM_OP_MULCH;
            else if (w[10:1] == SMRM_XO_MULHHWU || w[10:1] == XO_MULHHW_SIGNED) op = SMRM_OP_MULHH;
        end
        return op;
    endfunction : smrm_classify

    smrm_op_e cur_op;
    logic [9:0] swapped_num;
    smrm_state_s q;
    smrm_state_s d;
    smrm_mul_if mul_bus ();

    assign cur_op = smrm_classify(instr);
    assign swapped_num = smrm_swap_half(instr[20:11]); // RULE1 RULE7 RULE10

    // ==========================================================
    // Multiplier hookup
    // ==========================================================
    assign mul_bus.a = ra_val;
    assign mul_bus.b = rb_val;
    assign mul_bus.sel = (cur_op == SMRM_OP_MULCH) ? SMRM_MUL_CROSS :
                         (cur_op == SMRM_OP_MULHH) ? SMRM_MUL_HIGH : SMRM_MUL_WORD;
    // Signedness comes from the opcode alone; there is no overflow-enable path.
    assign mul_bus.sgn = (instr[10:1] == XO_MULCHW_SIGNED) || (instr[10:1] == XO_MULHHW_SIGNED) ||
                         (instr[31:26] == SMRM_PRI_MAIN && instr[9:1] == SMRM_XO_MULHW); // RULE13

    smrm_mul u_mul (
        .m(mul_bus.unit)
    );

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        d = q; // RULE6
        d.done = 1'b0;
        d.wb_en = 1'b0;
        d.dcr_we = 1'b0;
        d.spr_we = 1'b0;
        d.msr_we = 1'b0;
        d.exec_sync = 1'b0;
        d.priv_fault = 1'b0;
        d.invalid_form = 1'b0;
        if (issue_valid) begin
            case (cur_op)
                SMRM_OP_MFTB: begin
                    d.done = 1'b1;
                    d.wb_en = 1'b1;
                    d.wb_idx = instr[25:21];
                    if (swapped_num == SMRM_TBN_LOWER) begin
                        d.wb_data = tb_lower; // RULE1 RULE2
                    end else if (swapped_num == SMRM_TBN_UPPER) begin
                        d.wb_data = tb_upper; // RULE1 RULE2
                    end else begin
                        d.wb_data = SMRM_UNDEF_VALUE; // RULE3
                        d.invalid_form = 1'b1; // RULE3
                    end
                end
                SMRM_OP_MTCRF: begin
                    d.done = 1'b1;
                    // Full write is just the all-ones mask, so no separate path exists.
                    d.cr = smrm_cr_merge(q.cr, rs_val, instr[19:12]); // RULE4 RULE5
                end
                SMRM_OP_MTDCR: begin
                    d.done = 1'b1;
                    if (user_mode) begin
                        d.priv_fault = 1'b1; // RULE8
                    end else if (swapped_num >= SMRM_DCRN_LIMIT) begin
                        d.invalid_form = 1'b1; // RULE7
                    end else begin
                        d.dcr_we = 1'b1; // RULE7
                        d.move_num = swapped_num;
                        d.move_data = rs_val;
                    end
                end
                SMRM_OP_MTMSR: begin
                    d.done = 1'b1;
                    if (user_mode) begin
                        d.priv_fault = 1'b1; // RULE9
                    end else begin
                        d.msr_we = 1'b1; // RULE9
                        d.exec_sync = 1'b1; // RULE9
                        d.move_data = rs_val;
                    end
                end
                SMRM_OP_MTSPR: begin
                    d.done = 1'b1;
                    if (user_mode && instr[SMRM_SPR_PRIV_BIT]) begin
                        d.priv_fault = 1'b1; // RULE10
                    end else begin
                        d.spr_we = 1'b1; // RULE10
                        d.move_num = swapped_num;
                        d.move_data = rs_val;
                    end
                end
                SMRM_OP_MULCH, SMRM_OP_MULHH, SMRM_OP_MULHW: begin
                    d.done = 1'b1;
                    d.wb_en = 1'b1;
                    d.wb_idx = instr[25:21];
                    d.wb_data = mul_bus.prod; // RULE11 RULE12 RULE14 RULE16
                    if (instr[SMRM_RC_BIT]) begin
                        d.cr[31:28] = smrm_cr0(mul_bus.prod, xer_so); // RULE15 RULE17
                    end
                end
                default: begin
                end
            endcase
        end
        // Moves with bit 31 set simply keep the first condition field; that is one legal undefined value.
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '{default: '0, cr: SMRM_CR_RESET};
        end else begin
            q <= d;
        end
    end

    assign done_q = q.done;
    assign wb_en_q = q.wb_en;
    assign wb_idx_q = q.wb_idx;
    assign wb_data_q = q.wb_data;
    assign cr_q = q.cr;
    assign dcr_we_q = q.dcr_we;
    assign spr_we_q = q.spr_we;
    assign msr_we_q = q.msr_we;
    assign move_num_q = q.move_num;
    assign move_data_q = q.move_data;
    assign exec_sync_q = q.exec_sync;
    assign priv_fault_q = q.priv_fault;
    assign invalid_form_q = q.invalid_form;

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence s_tb_lower;
        issue_valid && cur_op == SMRM_OP_MFTB && instr[20:11] == SMRM_TBF_LOWER;
    endsequence
    sequence s_tb_upper;
        issue_valid && cur_op == SMRM_OP_MFTB && instr[20:11] == SMRM_TBF_UPPER;
    endsequence
    sequence s_priv_issue(smrm_op_e op);
        issue_valid && cur_op == op && !user_mode;
    endsequence

    property p_tb_lower;
        s_tb_lower |=> wb_en_q && wb_idx_q == $past(instr[25:21]) && wb_data_q == $past(tb_lower);
    endproperty
    a_tb_lower: assert property (p_tb_lower) else $error("time base lower word not moved"); // RULE1

    property p_tb_upper;
        s_tb_upper |=> wb_en_q && !invalid_form_q && wb_data_q == $past(tb_upper);
    endproperty
    a_tb_upper: assert property (p_tb_upper) else $error("time base upper word not moved"); // RULE2

    property p_tb_invalid;
        issue_valid && cur_op == SMRM_OP_MFTB && instr[20:11] != SMRM_TBF_LOWER
            && instr[20:11] != SMRM_TBF_UPPER |=> invalid_form_q && done_q;
    endproperty
    a_tb_invalid: assert property (p_tb_invalid) else $error("bad time base number not flagged"); // RULE3

    property p_cr_fields;
        issue_valid && cur_op == SMRM_OP_MTCRF |=>
            cr_q == smrm_cr_merge($past(cr_q), $past(rs_val), $past(instr[19:12]));
    endproperty
    a_cr_fields: assert property (p_cr_fields) else $error("masked condition write wrong"); // RULE4

    property p_cr_all;
        issue_valid && cur_op == SMRM_OP_MTCRF && instr[19:12] == SMRM_MASK_ALL |=> cr_q == $past(rs_val);
    endproperty
    a_cr_all: assert property (p_cr_all) else $error("full condition write wrong"); // RULE5

    property p_dcr_write;
        s_priv_issue(SMRM_OP_MTDCR) ##0 swapped_num < SMRM_DCRN_LIMIT |=>
            dcr_we_q && move_num_q == $past(swapped_num) && move_data_q == $past(rs_val) ##1
            dcr_we_q == $past(issue_valid && cur_op == SMRM_OP_MTDCR && !user_mode && swapped_num < SMRM_DCRN_LIMIT);
    endproperty
    a_dcr_write: assert property (p_dcr_write) else $error("device-control write wrong"); // RULE7

    property p_dcr_priv;
        issue_valid && cur_op == SMRM_OP_MTDCR && user_mode |=> priv_fault_q && !dcr_we_q;
    endproperty
    a_dcr_priv: assert property (p_dcr_priv) else $error("user device-control write not refused"); // RULE8

    property p_msr_write;
        s_priv_issue(SMRM_OP_MTMSR) |=> msr_we_q && exec_sync_q && move_data_q == $past(rs_val);
    endproperty
    a_msr_write: assert property (p_msr_write) else $error("machine-state write wrong"); // RULE9

    property p_spr_priv;
        issue_valid && cur_op == SMRM_OP_MTSPR |=>
            (spr_we_q != priv_fault_q) && (priv_fault_q == ($past(user_mode) && $past(instr[20])));
    endproperty
    a_spr_priv: assert property (p_spr_priv) else $error("special write privilege wrong"); // RULE10

    property p_mul_high_word;
        issue_valid && instr[31:26] == SMRM_PRI_MAIN && instr[10:1] == {1'b0, SMRM_XO_MULHW} |=>
            wb_data_q == 32'(({{32{$past(ra_val[31])}}, $past(ra_val)} *
                              {{32{$past(rb_val[31])}}, $past(rb_val)}) >> 32);
    endproperty
    a_mul_high_word: assert property (p_mul_high_word) else $error("signed high word product wrong"); // RULE14

    property p_mul_record;
        issue_valid && (cur_op == SMRM_OP_MULCH || cur_op == SMRM_OP_MULHH || cur_op == SMRM_OP_MULHW)
            && instr[SMRM_RC_BIT] |=> cr_q[31:28] == smrm_cr0(wb_data_q, $past(xer_so)) && cr_q[27:0] == $past(cr_q[27:0]);
    endproperty
    a_mul_record: assert property (p_mul_record) else $error("record flags wrong"); // RULE15

endmodule : smrm_exec

`default_nettype wire

// File: smrm_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Self-checking bench for the move and multiply execution block
// ==========================================================
module smrm_exec_tb
    import smrm_pkg::*;
;
    localparam logic [9:0] XO_CS = 10'h0A8;
    localparam logic [9:0] XO_HS = 10'h028;

    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic issue_valid = 1'b0;
    logic [31:0] instr = 32'h0000_0000;
    logic [31:0] ra_val = 32'h0000_0000;
    logic [31:0] rb_val = 32'h0000_0000;
    logic [31:0] rs_val = 32'h0000_0000;
    logic user_mode = 1'b0;
    logic xer_so = 1'b0;
    logic [31:0] tb_lower = 32'h1234_5678;
    logic [31:0] tb_upper = 32'h9ABC_DEF0;
    logic done_q, wb_en_q, dcr_we_q, spr_we_q, msr_we_q, exec_sync_q, priv_fault_q, invalid_form_q;
    logic [4:0] wb_idx_q;
    logic [31:0] wb_data_q, cr_q, move_data_q;
    logic [9:0] move_num_q;
    wire logic [7:0] strb;
    int n_mismatch = 0;
    int total_checks = 0;
    int mv = 0;
    logic [31:0] exp_cr = 32'h0000_0000;
    logic [31:0] rs, r, i;
    logic rc;
    logic [7:0] mlist [5] = '{8'hFF, 8'h81, 8'h5A, 8'h00, 8'h3C};
    logic [31:0] ra_t [3] = '{32'h8001_FFFE, 32'h0003_7FFF, 32'h0000_0000};
    logic [31:0] rb_t [3] = '{32'hFFFF_8003, 32'h8005_0007, 32'h1234_5678};

    always #2 clk = ~clk;

    assign strb = {done_q, wb_en_q, dcr_we_q, spr_we_q, msr_we_q, exec_sync_q, priv_fault_q, invalid_form_q};

    smrm_exec #(
        .XO_MULCHW_SIGNED(XO_CS),
        .XO_MULHHW_SIGNED(XO_HS)
    ) dut_u (
        .clk(clk), .resetn(resetn), .issue_valid(issue_valid), .instr(instr),
        .ra_val(ra_val), .rb_val(rb_val), .rs_val(rs_val), .user_mode(user_mode),
        .xer_so(xer_so), .tb_lower(tb_lower), .tb_upper(tb_upper),
        .done_q(done_q), .wb_en_q(wb_en_q), .wb_idx_q(wb_idx_q), .wb_data_q(wb_data_q),
        .cr_q(cr_q), .dcr_we_q(dcr_we_q), .spr_we_q(spr_we_q), .msr_we_q(msr_we_q),
        .move_num_q(move_num_q), .move_data_q(move_data_q), .exec_sync_q(exec_sync_q),
        .priv_fault_q(priv_fault_q), .invalid_form_q(invalid_form_q)
    );

    // ==========================================================
    // Expected-value helpers
    // ==========================================================
    function automatic logic [31:0] mk(input logic [5:0] pri, input logic [4:0] rt, input logic [9:0] f,
                                       input logic [9:0] xo, input logic rcb);
        return {pri, rt, f, xo, rcb};
    endfunction : mk

    // The swap is its own inverse, so it both encodes and decodes numbers.
    function automatic logic [9:0] sw(input logic [9:0] n);
        return {n[4:0], n[9:5]};
    endfunction : sw

    function automatic logic [31:0] merge(input logic [31:0] c, input logic [31:0] s, input logic [7:0] m);
        for (int k = 0; k < 8; k++) begin
            if (m[k]) begin
                c[4*k +: 4] = s[4*k +: 4];
            end
        end
        return c;
    endfunction : merge

    // Widened operands keep the product exact, so no saturation can hide here.
    function automatic logic [31:0] mul_exp(input int kind, input logic sgn, input logic [31:0] a,
                                            input logic [31:0] b);
        logic [15:0] x;
        logic [15:0] y;
        logic [63:0] p;
        x = (kind == 0) ? a[15:0] : a[31:16];
        y = b[31:16];
        if (kind == 2) begin
            p = {{32{sgn & a[31]}}, a} * {{32{sgn & b[31]}}, b};
            return p[63:32];
        end
        p = {{48{sgn & x[15]}}, x} * {{48{sgn & y[15]}}, y};
        return p[31:0];
    endfunction : mul_exp

    // ==========================================================
    // Compare tasks, issue tasks and verdict
    // ==========================================================
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_strb(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] care);
        total_checks++;
        if ((got & care) !== (exp & care)) begin
            n_mismatch++;
            $display("MISMATCH at %0t: strobes %b, expected %b", $time, got, exp);
        end
    endtask : chk_strb

    // Holding issue_valid between calls issues back to back; the answer is one edge later.
    task automatic send(input logic [31:0] w, input logic [31:0] a, input logic [31:0] b,
                        input logic [31:0] s, input logic um);
        instr = w;
        ra_val = a;
        rb_val = b;
        rs_val = s;
        user_mode = um;
        issue_valid = 1'b1;
        @(posedge clk);
        #1;
    endtask : send

    task automatic move_case(input logic [31:0] w, input logic um, input logic [7:0] es, input logic [9:0] en);
        logic [31:0] d;
        d = 32'hCAFE_0000 + 32'(mv);
        mv++;
        send(w, 32'h0, 32'h0, d, um);
        chk_strb(strb, es, 8'hFF);
        if (es[5] | es[4]) begin
            chk_word({22'h0, move_num_q}, {22'h0, en});
        end
        if (es[5] | es[4] | es[3]) begin
            chk_word(move_data_q, d);
        end
    endtask : move_case

    task automatic give_verdict();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        repeat (16) @(posedge clk);
        #1;
        resetn = 1'b1;
        chk_word(cr_q, SMRM_CR_RESET);
        chk_strb(strb, 8'h00, 8'hFF);
        send(mk(SMRM_PRI_MAIN, 5'h05, SMRM_TBF_LOWER, SMRM_XO_MFTB, 1'b0), 0, 0, 0, 1'b1);
        chk_strb(strb, 8'hC0, 8'hFF);
        chk_word({27'h0, wb_idx_q}, 32'h0000_0005);
        chk_word(wb_data_q, tb_lower);
        send(mk(SMRM_PRI_MAIN, 5'h1F, sw(SMRM_TBN_UPPER), SMRM_XO_MFTB, 1'b0), 0, 0, 0, 1'b1);
        chk_word({27'h0, wb_idx_q}, 32'h0000_001F);
        chk_word(wb_data_q, tb_upper);
        send(mk(SMRM_PRI_MAIN, 5'h04, sw(10'h10E), SMRM_XO_MFTB, 1'b0), 0, 0, 0, 1'b0);
        chk_strb(strb, 8'hC1, 8'hFF);
        chk_word(wb_data_q, SMRM_UNDEF_VALUE);
        send(mk(SMRM_PRI_MAIN, 5'h01, 10'h000, 10'h3FF, 1'b0), 0, 0, 0, 1'b0);
        chk_strb(strb, 8'h00, 8'hFF);
        for (int k = 0; k < 5; k++) begin
            rs = 32'h1234_5678 + 32'(k) * 32'h1111_1111;
            send(mk(SMRM_PRI_MAIN, 5'h03, {1'b0, mlist[k], 1'b0}, SMRM_XO_MTCRF, 1'b0), 0, 0, rs, 1'b1);
            exp_cr = merge(exp_cr, rs, mlist[k]);
            chk_strb(strb, 8'h80, 8'hFF);
            chk_word(cr_q, exp_cr);
        end
        send(mk(SMRM_PRI_MAIN, 5'h03, {1'b0, 8'h01, 1'b0}, SMRM_XO_MTCRF, 1'b1), 0, 0, 32'hFFFF_FFFF, 1'b0);
        exp_cr = merge(exp_cr, 32'hFFFF_FFFF, 8'h01);
        chk_word(cr_q, exp_cr);
        move_case(mk(SMRM_PRI_MAIN, 5'h02, sw(10'h0AB), SMRM_XO_MTDCR, 1'b1), 1'b0, 8'hA0, 10'h0AB);
        chk_word(cr_q, exp_cr);
        move_case(mk(SMRM_PRI_MAIN, 5'h02, sw(10'h0FF), SMRM_XO_MTDCR, 1'b0), 1'b0, 8'hA0, 10'h0FF);
        move_case(mk(SMRM_PRI_MAIN, 5'h02, sw(10'h100), SMRM_XO_MTDCR, 1'b0), 1'b0, 8'h81, 10'h000);
        move_case(mk(SMRM_PRI_MAIN, 5'h02, sw(10'h0AB), SMRM_XO_MTDCR, 1'b0), 1'b1, 8'h82, 10'h000);
        move_case(mk(SMRM_PRI_MAIN, 5'h06, 10'h000, SMRM_XO_MTMSR, 1'b0), 1'b0, 8'h8C, 10'h000);
        move_case(mk(SMRM_PRI_MAIN, 5'h06, 10'h000, SMRM_XO_MTMSR, 1'b0), 1'b1, 8'h82, 10'h000);
        move_case(mk(SMRM_PRI_MAIN, 5'h08, sw(10'h100), SMRM_XO_MTSPR, 1'b0), 1'b1, 8'h90, 10'h100);
        move_case(mk(SMRM_PRI_MAIN, 5'h08, sw(10'h110), SMRM_XO_MTSPR, 1'b0), 1'b1, 8'h82, 10'h000);
        move_case(mk(SMRM_PRI_MAIN, 5'h08, sw(10'h110), SMRM_XO_MTSPR, 1'b0), 1'b0, 8'h90, 10'h110);
        for (int s = 0; s < 3; s++) begin
            rc = (s != 1);
            xer_so = s[1];
            for (int k = 0; k < 6; k++) begin
                case (k)
                    0: i = mk(SMRM_PRI_HALF, 5'h07, 10'h022, XO_CS, rc);
                    1: i = mk(SMRM_PRI_HALF, 5'h07, 10'h022, SMRM_XO_MULCHWU, rc);
                    2: i = mk(SMRM_PRI_HALF, 5'h07, 10'h022, XO_HS, rc);
                    3: i = mk(SMRM_PRI_HALF, 5'h07, 10'h022, SMRM_XO_MULHHWU, rc);
                    4: i = mk(SMRM_PRI_MAIN, 5'h07, 10'h022, {1'b0, SMRM_XO_MULHW}, rc);
                    default: i = mk(SMRM_PRI_MAIN, 5'h07, 10'h022, {1'b0, SMRM_XO_MULHWU}, rc);
                endcase
                send(i, ra_t[s], rb_t[s], 32'h0, 1'b0);
                r = mul_exp(k / 2, ~k[0], ra_t[s], rb_t[s]);
                if (rc) begin
                    exp_cr[31:28] = {r[31], ~r[31] & (r != 0), r == 0, xer_so};
                end
                chk_strb(strb, 8'hC0, 8'hFF);
                chk_word(wb_data_q, r);
                chk_word(cr_q, exp_cr);
            end
        end
        issue_valid = 1'b0;
        @(posedge clk);
        #1;
        chk_strb(strb, 8'h00, 8'hFF);
        give_verdict();
    end
endmodule : smrm_exec_tb

`default_nettype wire
